// [common/mst_pkg.sv]
package mst_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int FIXED_OFF_TIME_NS = 30000;
  localparam logic [15:0] FIXED_OFF_CYCLES =
    16'(FIXED_OFF_TIME_NS / CLK_PERIOD_NS);
  localparam logic [15:0] US_CYCLES = 16'(NS_PER_US / CLK_PERIOD_NS);
  // Fast share of a mixed off-time is 5/16
  localparam logic [19:0] FAST_NUM = 20'h00005;
  localparam int FAST_SHIFT = 4;
  localparam logic [15:0] MIN_CYCLES = 16'h0001;

  // ----------------------------------------------------------------
  // Translator
  // ----------------------------------------------------------------
  localparam int POS_W = 6;
  localparam int DAC_W = 8;
  localparam logic [5:0] HOME_POS = 6'h08;
  localparam logic [5:0] QUARTER_SPAN = 6'h10;
  localparam logic [4:0] QUARTER_END = 5'h10;
  localparam logic [2:0] SEL_FULL = 3'h0;
  localparam logic [2:0] SEL_HALF = 3'h1;
  localparam logic [2:0] SEL_QUARTER = 3'h2;
  localparam logic [2:0] SEL_EIGHTH = 3'h3;
  localparam logic [2:0] SEL_SIXTEENTH = 3'h7;
  localparam logic [5:0] INC_FULL = 6'h10;
  localparam logic [5:0] INC_HALF = 6'h08;
  localparam logic [5:0] INC_QUARTER = 6'h04;
  localparam logic [5:0] INC_EIGHTH = 6'h02;
  localparam logic [5:0] INC_SIXTEENTH = 6'h01;
  localparam logic [1:0] OFF_TIME_SETTING_PIN_TO_VDD = 2'h0;
  localparam logic [1:0] OFF_TIME_SETTING_PIN_TO_GND = 2'h1;
  localparam logic [1:0] OFF_TIME_SETTING_PIN_RESISTOR = 2'h2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_OFF_TIME_SETTING_PIN_LSB = 0;
  localparam int CTRL_OFFUS_LSB = 8;
  localparam logic [1:0] CTRL_OFF_TIME_SETTING_PIN_RST = OFF_TIME_SETTING_PIN_TO_VDD;
  localparam logic [7:0] CTRL_OFFUS_RST = 8'h1e;
  localparam int ST_DAC_A_LSB = 0;
  localparam int ST_DAC_B_LSB = 8;
  localparam int ST_POL_A = 16;
  localparam int ST_POL_B = 17;
  localparam int ST_MIX_A = 18;
  localparam int ST_MIX_B = 19;
  localparam int ST_RES_LSB = 20;
  localparam int ST_POS_LSB = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    MST_DRIVE = 3'b001,
    MST_FAST = 3'b010,
    MST_SLOW = 3'b100
  } mst_chop_state_t;

  typedef struct packed
  {
    logic drive_on;
    logic fast_decay;
    logic slow_decay;
  } mst_chop_t;

  typedef struct packed
  {
    logic [DAC_W-1:0] dac;
    logic pol;
    logic decay_mixed;
    mst_chop_t chop;
  } mst_bridge_t;

endpackage

// [logic/mst_sync.sv]
`timescale 1ns/10ps
module mst_sync
#(
  parameter int W = 6
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// [logic/mst_off_timer.sv]
`timescale 1ns/10ps
module mst_off_timer
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic active,
  input wire logic trip,
  input wire logic mixed,
  input wire logic [15:0] off_cycles,
  input wire logic [15:0] fast_cycles,
  output mst_pkg::mst_chop_t chop
);

  mst_pkg::mst_chop_state_t state_ff;
  mst_pkg::mst_chop_state_t nxt_state;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [15:0] cnt_inc;

  always_comb
  begin
    cnt_inc = cnt_ff + mst_pkg::MIN_CYCLES;
    nxt_state = state_ff;
    nxt_cnt = cnt_inc;
    case (state_ff)
      mst_pkg::MST_DRIVE:
      begin
        nxt_cnt = '0;
        if (trip)
          nxt_state = mixed ? mst_pkg::MST_FAST : mst_pkg::MST_SLOW;
      end
      mst_pkg::MST_FAST:
      begin
        if (cnt_inc >= fast_cycles)
          nxt_state = mst_pkg::MST_SLOW;
      end
      mst_pkg::MST_SLOW:
      begin
        if (cnt_inc >= off_cycles)
          nxt_state = mst_pkg::MST_DRIVE;
      end
      default:
      begin
        nxt_state = mst_pkg::MST_DRIVE;
      end
    endcase
    // Disabled bridge restarts cleanly on the drive phase
    if (!active)
    begin
      nxt_state = mst_pkg::MST_DRIVE;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= mst_pkg::MST_DRIVE;
      cnt_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign chop.drive_on = state_ff == mst_pkg::MST_DRIVE;
  assign chop.fast_decay = state_ff == mst_pkg::MST_FAST;
  assign chop.slow_decay = state_ff == mst_pkg::MST_SLOW;

endmodule

// [logic/mst_translator.sv]
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - Select pins decode to full, half, quarter, eighth, sixteenth step.
// - Power-on or reset loads Home codes, polarities and Mixed decay.
// - Each accepted step moves both windings to the next table entry.
// - Automatic mode: falling winding level selects Mixed decay, except in full step (Slow).
// - Automatic mode: rising or equal winding level selects Slow decay.
// - New resolution takes effect only at the next step rising edge.
// - Fault-caused internal reset returns the translator to Home.
// - Mixed off-time: fast decay for 31.25 percent, then slow decay.
// - Off-time pin grounded forces Mixed decay always.
// - Off-time pin grounded gives a fixed 30 us off-time.
// - Reset input held low keeps Home and every FET off.
// - Step edges are ignored while the reset input is low.
// - One step rising edge advances exactly one increment.
// - Direction picks sequence order, sampled at the step rising edge.
// - Off-time pin at supply: automatic decay, 30 us, Slow in full step.
// - Output disable turns FETs off; sequencing keeps running.
module mst_translator
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic [2:0] resolution_select_bus,
  input wire logic translator_reset_n,
  input wire logic output_disable,
  input wire logic fault_home,
  input wire logic trip_a,
  input wire logic trip_b,
  output mst_pkg::mst_bridge_t bridge_a,
  output mst_pkg::mst_bridge_t bridge_b
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Quarter-wave level table, index 0..16
  function automatic logic [7:0] quarter_level(input logic [4:0] k);
    case (k)
      5'h00: quarter_level = 8'h00;
      5'h01: quarter_level = 8'h19;
      5'h02: quarter_level = 8'h32;
      5'h03: quarter_level = 8'h4a;
      5'h04: quarter_level = 8'h62;
      5'h05: quarter_level = 8'h78;
      5'h06: quarter_level = 8'h8e;
      5'h07: quarter_level = 8'ha2;
      5'h08: quarter_level = 8'hb5;
      5'h09: quarter_level = 8'hc6;
      5'h0a: quarter_level = 8'hd5;
      5'h0b: quarter_level = 8'he2;
      5'h0c: quarter_level = 8'hed;
      5'h0d: quarter_level = 8'hf5;
      5'h0e: quarter_level = 8'hfb;
      5'h0f: quarter_level = 8'hfe;
      default: quarter_level = 8'hff;
    endcase
  endfunction

  function automatic logic [7:0] wave_level(input logic [5:0] pos);
    logic [4:0] k;
    k = {1'b0, pos[3:0]};
    if (pos[4])
      wave_level = quarter_level(mst_pkg::QUARTER_END - k);
    else
      wave_level = quarter_level(k);
  endfunction

  function automatic logic [5:0] step_incr(input logic [2:0] sel);
    case (sel)
      mst_pkg::SEL_FULL: step_incr = mst_pkg::INC_FULL;
      mst_pkg::SEL_HALF: step_incr = mst_pkg::INC_HALF;
      mst_pkg::SEL_QUARTER: step_incr = mst_pkg::INC_QUARTER;
      mst_pkg::SEL_EIGHTH: step_incr = mst_pkg::INC_EIGHTH;
      mst_pkg::SEL_SIXTEENTH: step_incr = mst_pkg::INC_SIXTEENTH;
      default: step_incr = mst_pkg::INC_FULL;
    endcase
  endfunction

  function automatic logic pick_mixed(
    input logic [7:0] new_lvl,
    input logic [7:0] old_lvl,
    input logic [2:0] sel,
    input logic [1:0] off_time_setting_pin
  );
    if (off_time_setting_pin == mst_pkg::OFF_TIME_SETTING_PIN_TO_GND)
      pick_mixed = 1'b1;
    else if (step_incr(sel) == mst_pkg::INC_FULL)
      pick_mixed = 1'b0;
    else
      pick_mixed = new_lvl < old_lvl;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  logic step_s;
  logic dir_s;
  logic [2:0] sel_s;
  logic run_s;

  mst_sync #(.W(6)) u_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({translator_reset_n, resolution_select_bus, dir_in, step_in}),
    .sync_out(pins_s)
  );

  assign step_s = pins_s[0];
  assign dir_s = pins_s[1];
  assign sel_s = pins_s[4:2];
  assign run_s = pins_s[5];

  // ----------------------------------------------------------------
  // Registers over AHB-Lite
  // ----------------------------------------------------------------
  logic [1:0] off_time_setting_pin_ff;
  logic [1:0] nxt_off_time_setting_pin;
  logic [7:0] offus_ff;
  logic [7:0] nxt_offus;
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [7:0] wr_addr_ff;
  logic [7:0] nxt_wr_addr;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic addr_phase;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [5:0] pos_ff;
  logic [2:0] res_ff;

  assign addr_phase = hsel & hready & (htrans == mst_pkg::HTRANS_NONSEQ);

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[mst_pkg::CTRL_OFF_TIME_SETTING_PIN_LSB +: 2] = off_time_setting_pin_ff;
    ctrl_word[mst_pkg::CTRL_OFFUS_LSB +: 8] = offus_ff;
    status_word = '0;
    status_word[mst_pkg::ST_DAC_A_LSB +: 8] = bridge_a.dac;
    status_word[mst_pkg::ST_DAC_B_LSB +: 8] = bridge_b.dac;
    status_word[mst_pkg::ST_POL_A] = bridge_a.pol;
    status_word[mst_pkg::ST_POL_B] = bridge_b.pol;
    status_word[mst_pkg::ST_MIX_A] = bridge_a.decay_mixed;
    status_word[mst_pkg::ST_MIX_B] = bridge_b.decay_mixed;
    status_word[mst_pkg::ST_RES_LSB +: 3] = res_ff;
    status_word[mst_pkg::ST_POS_LSB +: 6] = pos_ff;
    nxt_wr_pend = addr_phase & hwrite;
    nxt_wr_addr = haddr[7:0];
    nxt_rdata = '0;
    // Read data settles in the data phase; unmapped reads give zero
    if (addr_phase && !hwrite)
    begin
      if (haddr[7:0] == mst_pkg::ADDR_CTRL)
        nxt_rdata = ctrl_word;
      else if (haddr[7:0] == mst_pkg::ADDR_STATUS)
        nxt_rdata = status_word;
    end
    nxt_off_time_setting_pin = off_time_setting_pin_ff;
    nxt_offus = offus_ff;
    if (wr_pend_ff && wr_addr_ff == mst_pkg::ADDR_CTRL)
    begin
      nxt_off_time_setting_pin = hwdata[mst_pkg::CTRL_OFF_TIME_SETTING_PIN_LSB +: 2];
      nxt_offus = hwdata[mst_pkg::CTRL_OFFUS_LSB +: 8];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      off_time_setting_pin_ff <= mst_pkg::CTRL_OFF_TIME_SETTING_PIN_RST;
      offus_ff <= mst_pkg::CTRL_OFFUS_RST;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      rdata_ff <= '0;
    end
    else
    begin
      off_time_setting_pin_ff <= nxt_off_time_setting_pin;
      offus_ff <= nxt_offus;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  // Zero wait states, never an error
  assign hreadyout = 1'b1;
  assign hresp = mst_pkg::HRESP_OKAY;
  assign hrdata = rdata_ff;

  // ----------------------------------------------------------------
  // Translator
  // ----------------------------------------------------------------
  logic step_prev_ff;
  logic [5:0] nxt_pos;
  logic [2:0] nxt_res;
  logic [7:0] lvl_a_ff;
  logic [7:0] lvl_b_ff;
  logic [7:0] nxt_lvl_a;
  logic [7:0] nxt_lvl_b;
  logic mix_a_ff;
  logic mix_b_ff;
  logic nxt_mix_a;
  logic nxt_mix_b;
  logic step_edge;
  logic home_req;
  logic [5:0] cand_pos;
  logic [7:0] cand_a;
  logic [7:0] cand_b;

  // Steps only count while the reset pin is released
  assign step_edge = step_s & ~step_prev_ff & run_s;
  assign home_req = ~run_s | fault_home;

  always_comb
  begin
    if (dir_s)
      cand_pos = pos_ff + step_incr(sel_s);
    else
      cand_pos = pos_ff - step_incr(sel_s);
    cand_a = wave_level(cand_pos);
    cand_b = wave_level(cand_pos + mst_pkg::QUARTER_SPAN);
    nxt_pos = pos_ff;
    nxt_res = res_ff;
    nxt_lvl_a = lvl_a_ff;
    nxt_lvl_b = lvl_b_ff;
    nxt_mix_a = mix_a_ff;
    nxt_mix_b = mix_b_ff;
    if (home_req)
    begin
      nxt_pos = mst_pkg::HOME_POS;
      nxt_lvl_a = wave_level(mst_pkg::HOME_POS);
      nxt_lvl_b = wave_level(mst_pkg::HOME_POS + mst_pkg::QUARTER_SPAN);
      nxt_mix_a = 1'b1;
      nxt_mix_b = 1'b1;
    end
    else if (step_edge)
    begin
      // Select and direction are taken only here
      nxt_res = sel_s;
      nxt_pos = cand_pos;
      nxt_lvl_a = cand_a;
      nxt_lvl_b = cand_b;
      nxt_mix_a = pick_mixed(cand_a, lvl_a_ff, sel_s, off_time_setting_pin_ff);
      nxt_mix_b = pick_mixed(cand_b, lvl_b_ff, sel_s, off_time_setting_pin_ff);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      step_prev_ff <= 1'b0;
      pos_ff <= mst_pkg::HOME_POS;
      res_ff <= mst_pkg::SEL_FULL;
      lvl_a_ff <= 8'hb5;
      lvl_b_ff <= 8'hb5;
      mix_a_ff <= 1'b1;
      mix_b_ff <= 1'b1;
    end
    else
    begin
      step_prev_ff <= step_s;
      pos_ff <= nxt_pos;
      res_ff <= nxt_res;
      lvl_a_ff <= nxt_lvl_a;
      lvl_b_ff <= nxt_lvl_b;
      mix_a_ff <= nxt_mix_a;
      mix_b_ff <= nxt_mix_b;
    end
  end

  // ----------------------------------------------------------------
  // Off-time and chopping
  // ----------------------------------------------------------------
  logic [15:0] off_cycles;
  logic [15:0] fast_cycles;
  logic [19:0] fast_prod;
  logic fets_off;
  logic eff_mix_a;
  logic eff_mix_b;
  mst_pkg::mst_chop_t chop_a;
  mst_pkg::mst_chop_t chop_b;

  always_comb
  begin
    if (off_time_setting_pin_ff == mst_pkg::OFF_TIME_SETTING_PIN_RESISTOR)
      off_cycles = 16'({8'h00, offus_ff} * mst_pkg::US_CYCLES);
    else
      off_cycles = mst_pkg::FIXED_OFF_CYCLES;
    if (off_cycles == '0)
      off_cycles = mst_pkg::MIN_CYCLES;
    fast_prod = {4'h0, off_cycles} * mst_pkg::FAST_NUM;
    fast_cycles = 16'(fast_prod >> mst_pkg::FAST_SHIFT);
    if (fast_cycles == '0)
      fast_cycles = mst_pkg::MIN_CYCLES;
  end

  // Grounded pin overrides even a stale Slow choice
  assign eff_mix_a = mix_a_ff | (off_time_setting_pin_ff == mst_pkg::OFF_TIME_SETTING_PIN_TO_GND);
  assign eff_mix_b = mix_b_ff | (off_time_setting_pin_ff == mst_pkg::OFF_TIME_SETTING_PIN_TO_GND);
  assign fets_off = ~run_s | output_disable;

  mst_off_timer u_timer_a
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .active(~fets_off),
    .trip(trip_a),
    .mixed(eff_mix_a),
    .off_cycles(off_cycles),
    .fast_cycles(fast_cycles),
    .chop(chop_a)
  );

  mst_off_timer u_timer_b
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .active(~fets_off),
    .trip(trip_b),
    .mixed(eff_mix_b),
    .off_cycles(off_cycles),
    .fast_cycles(fast_cycles),
    .chop(chop_b)
  );

  // ----------------------------------------------------------------
  // Bridge outputs
  // ----------------------------------------------------------------
  mst_pkg::mst_bridge_t out_a_ff;
  mst_pkg::mst_bridge_t out_b_ff;
  mst_pkg::mst_bridge_t nxt_out_a;
  mst_pkg::mst_bridge_t nxt_out_b;

  always_comb
  begin
    nxt_out_a.dac = lvl_a_ff;
    nxt_out_a.pol = ~pos_ff[5];
    nxt_out_a.decay_mixed = eff_mix_a;
    nxt_out_a.chop = fets_off ? '0 : chop_a;
    nxt_out_b.dac = lvl_b_ff;
    nxt_out_b.pol = ~(pos_ff[5] ^ pos_ff[4]);
    nxt_out_b.decay_mixed = eff_mix_b;
    nxt_out_b.chop = fets_off ? '0 : chop_b;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_a_ff <= '0;
      out_b_ff <= '0;
    end
    else
    begin
      out_a_ff <= nxt_out_a;
      out_b_ff <= nxt_out_b;
    end
  end

  assign bridge_a = out_a_ff;
  assign bridge_b = out_b_ff;

endmodule

// [test/mst_translator_monitor.sv]
`timescale 1ns/10ps
module mst_translator_monitor
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic step_in,
  input wire logic translator_reset_n,
  input wire logic output_disable,
  input wire logic fault_home,
  input mst_pkg::mst_bridge_t bridge_a,
  input mst_pkg::mst_bridge_t bridge_b
);
  localparam int OFF_CYC = 30 * 1000 / 10;
  localparam int FAST_CYC = OFF_CYC * 5 / 16;
  logic [11:0] fast_cnt_ff, nxt_fast_cnt, off_cnt_ff, nxt_off_cnt;
  logic home_ok, chop_off;
  logic [17:0] pos_view;

  assign home_ok = bridge_a.dac == 8'hb5 && bridge_b.dac == 8'hb5
    && bridge_a.pol && bridge_b.pol
    && bridge_a.decay_mixed && bridge_b.decay_mixed;
  assign chop_off = bridge_a.chop == 3'h0 && bridge_b.chop == 3'h0;
  assign pos_view = {bridge_a.dac, bridge_a.pol, bridge_b.dac, bridge_b.pol};

  // ------------------------------------------------------------
  // Off-time phase counters, bridge a only
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_fast_cnt = bridge_a.chop.fast_decay ? fast_cnt_ff + 12'h001 : 12'h000;
    nxt_off_cnt = (bridge_a.chop.fast_decay || bridge_a.chop.slow_decay) ?
      off_cnt_ff + 12'h001 : 12'h000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fast_cnt_ff <= 12'h000;
      off_cnt_ff <= 12'h000;
    end
    else
    begin
      fast_cnt_ff <= nxt_fast_cnt;
      off_cnt_ff <= nxt_off_cnt;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_home_after_reset;
    $rose(hresetn) |=> home_ok;
  endproperty
  a_home_after_reset: assert property (p_home_after_reset)
    else $error("bridges not at home after reset");

  property p_pin_reset_home;
    (!translator_reset_n)[*6] |-> home_ok && chop_off;
  endproperty
  a_pin_reset_home: assert property (p_pin_reset_home)
    else $error("reset pin low but not home or fets on");

  property p_pin_reset_frozen;
    (!translator_reset_n)[*6] |-> $stable(pos_view);
  endproperty
  a_pin_reset_frozen: assert property (p_pin_reset_frozen)
    else $error("translator moved while reset pin low");

  property p_fault_home;
    fault_home[*5] |-> home_ok;
  endproperty
  a_fault_home: assert property (p_fault_home)
    else $error("fault did not return translator home");

  // Synchroniser plus decode: new codes appear on the fourth edge
  property p_step_moves;
    (translator_reset_n && !fault_home)[*6] ##0 $rose(step_in) |->
      ##1 $stable(pos_view)[*3] ##1 !$stable(pos_view);
  endproperty
  a_step_moves: assert property (p_step_moves)
    else $error("step edge did not move translator on time");

  property p_disable_off;
    output_disable[*5] |-> chop_off;
  endproperty
  a_disable_off: assert property (p_disable_off)
    else $error("fets on while outputs disabled");

  property p_fast_share;
    $fell(bridge_a.chop.fast_decay) |-> fast_cnt_ff == FAST_CYC;
  endproperty
  a_fast_share: assert property (p_fast_share)
    else $error("fast decay share wrong");

  property p_off_total;
    $rose(bridge_a.chop.drive_on) && $past(bridge_a.chop.slow_decay) |->
      off_cnt_ff == OFF_CYC;
  endproperty
  a_off_total: assert property (p_off_total)
    else $error("off time length wrong");
endmodule

bind mst_translator mst_translator_monitor u_mst_translator_monitor
(
  .hclk(hclk), .hresetn(hresetn), .step_in(step_in),
  .translator_reset_n(translator_reset_n), .output_disable(output_disable),
  .fault_home(fault_home), .bridge_a(bridge_a), .bridge_b(bridge_b)
);

// [test/mst_step_ctrl.sv]
`timescale 1ns/10ps
module mst_step_ctrl
(
  input wire logic clk,
  input wire logic go,
  input wire logic hold,
  input wire logic slow,
  input wire logic fwd,
  input wire logic [2:0] sel,
  output logic step_in,
  output logic dir_in,
  output logic [2:0] resolution_select_bus,
  output logic done
);
  int wid;
  initial
  begin
    step_in = 1'b0;
    dir_in = 1'b1;
    resolution_select_bus = 3'h0;
    done = 1'b0;
  end

  // Levels settle well ahead of the step edge and stay until next request
  always
  begin
    do @(posedge clk); while (go !== 1'b1);
    wid = slow ? 300 : 100;
    dir_in <= fwd;
    resolution_select_bus <= sel;
    repeat (20) @(posedge clk);
    step_in <= !hold;
    repeat (wid) @(posedge clk);
    step_in <= 1'b0;
    repeat (wid) @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  end
endmodule

// [test/tb_mst_translator.sv]
`timescale 1ns/10ps
module tb_mst_translator;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, step_in, dir_in, done;
  logic [31:0] hrdata;
  logic [2:0] sel_bus, req_sel = 3'h0;
  logic translator_reset_n = 1'b1;
  logic output_disable = 1'b0;
  logic fault_home = 1'b0;
  logic trip_a = 1'b0;
  logic go = 1'b0, hold = 1'b0, fwd = 1'b1, slow = 1'b0, gnd = 1'b0;
  mst_pkg::mst_bridge_t bridge_a, bridge_b;
  int n_fail = 0, checks_done = 0, nf, no;
  logic [5:0] pos = 6'h08;
  logic [2:0] codes [5] = '{mst_pkg::SEL_FULL, mst_pkg::SEL_HALF,
    mst_pkg::SEL_QUARTER, mst_pkg::SEL_EIGHTH, mst_pkg::SEL_SIXTEENTH};
  logic [5:0] incs [5] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h01};

  always #5 hclk = ~hclk;

  mst_translator u_mst_translator
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .step_in(step_in), .dir_in(dir_in),
    .resolution_select_bus(sel_bus), .translator_reset_n(translator_reset_n),
    .output_disable(output_disable), .fault_home(fault_home),
    .trip_a(trip_a), .trip_b(trip_a), .bridge_a(bridge_a), .bridge_b(bridge_b)
  );

  mst_step_ctrl u_mst_step_ctrl
  (
    .clk(hclk), .go(go), .hold(hold), .slow(slow), .fwd(fwd), .sel(req_sel),
    .step_in(step_in), .dir_in(dir_in), .resolution_select_bus(sel_bus),
    .done(done)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= mst_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Decay expectation uses the levels seen just before the step
  task step(input logic f, input logic [2:0] s, input logic h,
    input logic [5:0] ep);
    logic [7:0] oa, ob;
    logic ea, eb;
    oa = bridge_a.dac;
    ob = bridge_b.dac;
    @(posedge hclk);
    fwd <= f;
    req_sel <= s;
    hold <= h;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    for (int i = 0; i < 2000 && done !== 1'b1; i++) @(posedge hclk);
    repeat (4) @(posedge hclk);
    ea = gnd | !translator_reset_n | (s != 3'h0 && bridge_a.dac < oa);
    eb = gnd | !translator_reset_n | (s != 3'h0 && bridge_b.dac < ob);
    ahb(1'b0, mst_pkg::ADDR_STATUS, 32'h0);
    check({26'h0, rd[29:24]}, {26'h0, ep});
    if (!h)
    begin
      check({31'h0, bridge_a.decay_mixed}, {31'h0, ea});
      check({31'h0, bridge_b.decay_mixed}, {31'h0, eb});
    end
  endtask

  // One trip, then time the fast share and the whole off phase of bridge a
  task chop_run;
    for (int i = 0; i < 100 && bridge_a.chop.drive_on !== 1'b1; i++)
      @(posedge hclk);
    trip_a <= 1'b1;
    @(posedge hclk);
    trip_a <= 1'b0;
    nf = 0;
    no = 0;
    for (int i = 0; i < 4000; i++)
    begin
      @(posedge hclk);
      nf += int'(bridge_a.chop.fast_decay === 1'b1);
      if (bridge_a.chop.fast_decay === 1'b1 || bridge_a.chop.slow_decay === 1'b1)
        no++;
      else if (no > 0)
        break;
    end
    check(nf, 3000 * 5 / 16);
    check(no, 3000);
  endtask

  task tally_and_finish;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    ahb(1'b0, mst_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hff8fffff, 32'h080fb5b5);
    check({31'h0, hresp}, {31'h0, mst_pkg::HRESP_OKAY});
    ahb(1'b1, mst_pkg::ADDR_STATUS, 32'hffffffff);
    ahb(1'b0, mst_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h00001e00);
    ahb(1'b1, 8'h08, 32'h5a5a5a5a);
    ahb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    $display("test reset and registers done");
    chop_run;
    // Resistor mode set to the same 30 us so the monitor's span still holds
    ahb(1'b1, mst_pkg::ADDR_CTRL, 32'h00001e02);
    chop_run;
    ahb(1'b1, mst_pkg::ADDR_CTRL, 32'h00001e00);
    $display("test off time done");
    // Home is common to every resolution, so each mode starts there
    for (int k = 0; k < 5; k++)
    begin
      step(1'b1, codes[k], 1'b0, pos + incs[k]);
      check({29'h0, rd[22:20]}, {29'h0, codes[k]});
      step(1'b0, codes[k], 1'b0, pos);
    end
    step(1'b1, mst_pkg::SEL_HALF, 1'b1, 6'h08);
    check({29'h0, rd[22:20]}, {29'h0, mst_pkg::SEL_SIXTEENTH});
    step(1'b1, mst_pkg::SEL_HALF, 1'b0, 6'h10);
    step(1'b0, mst_pkg::SEL_HALF, 1'b0, 6'h08);
    $display("test resolutions done");
    gnd = 1'b1;
    ahb(1'b1, mst_pkg::ADDR_CTRL, 32'h00001e01);
    ahb(1'b0, mst_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h00001e01);
    chop_run;
    step(1'b1, mst_pkg::SEL_SIXTEENTH, 1'b0, 6'h09);
    step(1'b0, mst_pkg::SEL_SIXTEENTH, 1'b0, 6'h08);
    gnd = 1'b0;
    ahb(1'b1, mst_pkg::ADDR_CTRL, 32'h00001e00);
    $display("test grounded mode done");
    step(1'b1, mst_pkg::SEL_SIXTEENTH, 1'b0, 6'h09);
    translator_reset_n <= 1'b0;
    repeat (8) @(posedge hclk);
    ahb(1'b0, mst_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hff8fffff, 32'h080fb5b5);
    check({29'h0, bridge_a.chop | bridge_b.chop}, 32'h0);
    step(1'b1, mst_pkg::SEL_SIXTEENTH, 1'b0, 6'h08);
    translator_reset_n <= 1'b1;
    repeat (5) @(posedge hclk);
    step(1'b1, mst_pkg::SEL_SIXTEENTH, 1'b0, 6'h09);
    $display("test reset pin done");
    fault_home <= 1'b1;
    repeat (8) @(posedge hclk);
    fault_home <= 1'b0;
    repeat (8) @(posedge hclk);
    ahb(1'b0, mst_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hff8fffff, 32'h080fb5b5);
    $display("test fault home done");
    slow = 1'b1;
    output_disable <= 1'b1;
    step(1'b1, mst_pkg::SEL_SIXTEENTH, 1'b0, 6'h09);
    check({29'h0, bridge_a.chop | bridge_b.chop}, 32'h0);
    output_disable <= 1'b0;
    $display("test output disable done");
    tally_and_finish;
  end

  initial
  begin
    repeat (60000) @(posedge hclk);
    n_fail++;
    tally_and_finish;
  end
endmodule
